/* File: include/hirq_params.svh */
// Constants for the host interrupt status flag logic (status bits 5..7).
// Assumes inclusion by the bench and by every design file that needs a figure.
`ifndef HIRQ_PARAMS_SVH
`define HIRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HIRQ_ADDR_W 4
`define HIRQ_OFS_STATUS 4'h0
`define HIRQ_OFS_LINKCFG 4'h1
`define HIRQ_OFS_IRQCFG 4'h2
`define HIRQ_OFS_CTRL 4'h3
`define HIRQ_OFS_EVT 4'h4
`define HIRQ_OFS_MASK 4'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HIRQ_BIT_SYNC 5
`define HIRQ_BIT_DEBUG 6
`define HIRQ_BIT_RESET 7
`define HIRQ_BIT_ASYNC 0
`define HIRQ_BIT_CFGVAL 0
`define HIRQ_BIT_INITDONE 0
`define HIRQ_BIT_UPLOAD 1
`define HIRQ_BIT_FATAL 2
`define HIRQ_EVT_RESET 0
`define HIRQ_EVT_FATAL 1
`define HIRQ_EVT_DEBUG 2
`define HIRQ_EVT_W 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HIRQ_RST_BYTE 8'h00
`define HIRQ_RST_EVT 3'h0
`define HIRQ_RST_MASK 3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HIRQ_SYNC_WAIT 2'h2

`endif

/* File: include/hirq_pkg.sv */
// Types shared by the host interrupt status flag logic.
// Assumes nothing beyond a SystemVerilog compiler.
package hirq_pkg;

   // ----------------------------------------------------------------------
   // Reset-cause classes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      HIRQ_CAUSE_POR,
      HIRQ_CAUSE_WDOG,
      HIRQ_CAUSE_FATAL
   } hirq_cause_t;

   // ----------------------------------------------------------------------
   // Reset flag lifecycle
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      HIRQ_BOOT,
      HIRQ_INIT_DONE,
      HIRQ_RUN
   } hirq_state_t;

endpackage

/* File: verilog/hirq_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level; first stage is read by the second only.
`timescale 1ns/1ps
module hirq_sync
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic d,
   output logic q
);

   logic meta_r;

   // ----------------------------------------------------------------------
   // Two stages
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

/* File: verilog/hirq_regs.sv */
// Sticky event status with write-one-to-clear and mask, one level interrupt.
// Assumes one-cycle write strobe on the same clock; set wins over clear.
`timescale 1ns/1ps
`include "hirq_params.svh"
module hirq_regs
#(
   parameter int W = `HIRQ_EVT_W
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] set_in,
   input wire logic clr_we,
   input wire logic mask_we,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] evt_r,
   output logic [W-1:0] mask_r,
   output logic pend
);

   // ----------------------------------------------------------------------
   // Sticky bits
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         evt_r <= `HIRQ_RST_EVT;
      else if (ce)
         evt_r <= (evt_r & ~(clr_we ? wdata : '0)) | set_in;
   end

   // ----------------------------------------------------------------------
   // Mask, one bit disables the event
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         mask_r <= `HIRQ_RST_MASK;
      else if (ce && mask_we)
         mask_r <= wdata;
   end

   assign pend = |(evt_r & ~mask_r);

endmodule

/* File: verilog/hirq_status.sv */
// Upper flag bits of the host interrupt status word and the host interrupt line.
// Assumes FIFO, firmware strobes and reset-cause straps on the system clock,
// except the retained configuration pin, which arrives asynchronously.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "hirq_params.svh"

// Operation
// - Status bit 7 is set when a fatal error inside the device caused the interrupt.
// - Bit 7 is set after every reset and cleared once init is done and code upload has begun.
// - After an ordinary reset the interrupt line stays low until the host configures its type.
// - A watchdog or fatal reset may drive the interrupt if retained memory kept the configuration.
// - Bit 6 reads 0 while the status and debug FIFO is empty and 1 while it holds data.
// - With the asynchronous-mode flag clear, command responses are reported through bit 5.
module hirq_status
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [`HIRQ_ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] rst_cause,
   input wire logic retained_cfg_async,
   input wire logic fifo_not_empty,
   input wire logic resp_pending,
   input wire logic fatal_err,
   input wire logic init_done,
   input wire logic upload_start,
   output logic [7:0] rdata,
   output logic host_irq,
   output logic async_mode,
   output logic irq_cfg_valid
);

   hirq_pkg::hirq_state_t state_r;
   hirq_pkg::hirq_state_t state_nxt;
   hirq_pkg::hirq_cause_t cause_r;
   logic retained_s;
   logic retained_r;
   logic reset_flag_r;
   logic fatal_flag_r;
   logic debug_bit_r;
   logic sync_bit_r;
   logic first_r;
   logic [1:0] settle_r;
   logic capture;
   logic [2:0] evt_r;
   logic [2:0] mask_r;
   logic [2:0] evt_set;
   logic pend;
   logic irq_allowed;
   logic [7:0] status_byte;

   function automatic logic hit(input logic [`HIRQ_ADDR_W-1:0] a,
                                input logic [`HIRQ_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------------
   // Retained configuration pin
   // ----------------------------------------------------------------------
   hirq_sync u_sync
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d(retained_cfg_async),
      .q(retained_s)
   );

   // ----------------------------------------------------------------------
   // Cause and retained config caught once the synchroniser has flushed
   // ----------------------------------------------------------------------
   // Synchroniser is held in reset, so the pin is valid only two edges later
   always_ff @(posedge clk)
   begin
      if (rst)
         settle_r <= `HIRQ_SYNC_WAIT;
      else if (ce && settle_r != 2'h0)
         settle_r <= settle_r - 2'h1;
   end

   assign capture = first_r & (settle_r == 2'h0);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         first_r <= 1'b1;
         cause_r <= hirq_pkg::HIRQ_CAUSE_POR;
         retained_r <= 1'b0;
      end
      else if (ce && capture)
      begin
         first_r <= 1'b0;
         cause_r <= hirq_pkg::hirq_cause_t'(rst_cause);
         retained_r <= retained_s;
      end
   end

   // ----------------------------------------------------------------------
   // Host link configuration: asynchronous-mode flag
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         async_mode <= 1'b0;
      else if (ce && wr && hit(addr, `HIRQ_OFS_LINKCFG))
         async_mode <= wdata[`HIRQ_BIT_ASYNC];
   end

   // ----------------------------------------------------------------------
   // Interrupt configuration written by the host
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_cfg_valid <= 1'b0;
      else if (ce && wr && hit(addr, `HIRQ_OFS_IRQCFG))
         irq_cfg_valid <= wdata[`HIRQ_BIT_CFGVAL];
   end

   // ----------------------------------------------------------------------
   // Reset flag lifecycle
   // ----------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         hirq_pkg::HIRQ_BOOT:
            if (init_done)
               state_nxt = hirq_pkg::HIRQ_INIT_DONE;
         hirq_pkg::HIRQ_INIT_DONE:
            if (upload_start)
               state_nxt = hirq_pkg::HIRQ_RUN;
         hirq_pkg::HIRQ_RUN:
            state_nxt = hirq_pkg::HIRQ_RUN;
         default:
            state_nxt = hirq_pkg::HIRQ_BOOT;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state_r <= hirq_pkg::HIRQ_BOOT;
      else if (ce)
         state_r <= state_nxt;
   end

   // set at reset, clear after upload
   always_ff @(posedge clk)
   begin
      if (rst)
         reset_flag_r <= 1'b1;
      else if (ce && state_r == hirq_pkg::HIRQ_INIT_DONE && upload_start)
         reset_flag_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         fatal_flag_r <= 1'b0;
      else if (ce)
      begin
         if (fatal_err)
            fatal_flag_r <= 1'b1;
         else if (wr && hit(addr, `HIRQ_OFS_CTRL) && wdata[`HIRQ_BIT_FATAL])
            fatal_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // FIFO-driven bits
   // ----------------------------------------------------------------------
   // follows FIFO occupancy
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         debug_bit_r <= 1'b0;
         sync_bit_r <= 1'b0;
      end
      else if (ce)
      begin
         debug_bit_r <= fifo_not_empty;
         sync_bit_r <= resp_pending & ~async_mode;
      end
   end

   // ----------------------------------------------------------------------
   // Events and interrupt line
   // ----------------------------------------------------------------------
   // reset event once per reset
   assign evt_set = {fifo_not_empty & ~debug_bit_r, fatal_err, capture};

   hirq_regs #(.W(`HIRQ_EVT_W)) u_regs
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .set_in(evt_set),
      .clr_we(wr && hit(addr, `HIRQ_OFS_EVT)),
      .mask_we(wr && hit(addr, `HIRQ_OFS_MASK)),
      .wdata(wdata[`HIRQ_EVT_W-1:0]),
      .evt_r(evt_r),
      .mask_r(mask_r),
      .pend(pend)
   );

   // ordinary reset: wait for host config
   // watchdog or fatal with retained config
   assign irq_allowed = irq_cfg_valid |
                        (retained_r & (cause_r != hirq_pkg::HIRQ_CAUSE_POR));

   always_ff @(posedge clk)
   begin
      if (rst)
         host_irq <= 1'b0;
      else if (ce)
         host_irq <= pend & irq_allowed;
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   assign status_byte = {reset_flag_r | fatal_flag_r, debug_bit_r, sync_bit_r, 5'h00};

   always_ff @(posedge clk)
   begin
      if (rst)
         rdata <= `HIRQ_RST_BYTE;
      else if (ce)
      begin
         rdata <= `HIRQ_RST_BYTE;
         if (rd)
         begin
            case (addr)
               `HIRQ_OFS_STATUS: rdata <= status_byte;
               `HIRQ_OFS_LINKCFG: rdata <= {7'h00, async_mode};
               `HIRQ_OFS_IRQCFG: rdata <= {7'h00, irq_cfg_valid};
               `HIRQ_OFS_CTRL: rdata <= {5'h00, fatal_flag_r, ~reset_flag_r,
                                         state_r != hirq_pkg::HIRQ_BOOT};
               `HIRQ_OFS_EVT: rdata <= {5'h00, evt_r};
               `HIRQ_OFS_MASK: rdata <= {5'h00, mask_r};
               default: rdata <= `HIRQ_RST_BYTE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_cfg_low;
      !irq_cfg_valid && !retained_r;
   endsequence

   sequence s_por_unconfigured;
      !irq_cfg_valid && cause_r == hirq_pkg::HIRQ_CAUSE_POR;
   endsequence

   no_cfg_irq_a: assert property (@(posedge clk) disable iff (rst)
      s_cfg_low ##1 !irq_cfg_valid |-> !host_irq)
      else $error("interrupt driven before configuration");
   reset_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      $fell(reset_flag_r) |-> $past(state_r) == hirq_pkg::HIRQ_INIT_DONE && $past(upload_start))
      else $error("reset flag cleared early");
   debug_bit_track_a: assert property (@(posedge clk) disable iff (rst)
      ce |=> debug_bit_r == $past(fifo_not_empty))
      else $error("bit 6 does not follow FIFO");
   // sync bit only in sync mode
   sync_bit_mode_a: assert property (@(posedge clk) disable iff (rst)
      ce && async_mode |=> !sync_bit_r)
      else $error("bit 5 set in async mode");
   async_resp_a: assert property (@(posedge clk) disable iff (rst)
      ce && async_mode && fifo_not_empty |=> status_byte[`HIRQ_BIT_DEBUG])
      else $error("async response missing on bit 6");
   fatal_bit_a: assert property (@(posedge clk) disable iff (rst)
      ce && fatal_err |=> status_byte[`HIRQ_BIT_RESET] && fatal_flag_r)
      else $error("fatal error not on bit 7");
   retained_irq_a: assert property (@(posedge clk) disable iff (rst)
      ce && pend && retained_r && cause_r != hirq_pkg::HIRQ_CAUSE_POR |=> host_irq)
      else $error("retained config did not allow interrupt");
   read_port_a: assert property (@(posedge clk) disable iff (rst)
      ce && !rd |=> rdata == `HIRQ_RST_BYTE)
      else $error("read data outside read slot");
   // power-on reset keeps the line low
   por_no_irq_a: assert property (@(posedge clk) disable iff (rst)
      ce ##0 s_por_unconfigured |=> !host_irq)
      else $error("interrupt after power-on reset without configuration");
   // clock enable low freezes the flags
   ce_freeze_a: assert property (@(posedge clk) disable iff (rst)
      !ce |=> $stable(state_r) && $stable(evt_r) && $stable(fatal_flag_r) && $stable(host_irq))
      else $error("state moved while clock enable low");

endmodule

/* File: verif/hirq_fw_model.sv */
// Firmware-side partner: boot sequence strobes toward the status flag logic.
// Assumes the same system clock as the design and a synchronous high reset.
`timescale 1ns/1ps
module hirq_fw_model
#(
   parameter int DLY = 2
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   output logic init_done,
   output logic upload_start
);
   logic [3:0] cnt_r;
   logic run_r;

   // ----------------------------------------------------------------------
   // Boot sequence
   // ----------------------------------------------------------------------
   // init first, upload later
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= 4'h0;
         run_r <= 1'b0;
         init_done <= 1'b0;
         upload_start <= 1'b0;
      end
      else
      begin
         init_done <= run_r && (cnt_r == 4'(DLY));
         upload_start <= run_r && (cnt_r == 4'(2 * DLY));
         if (go && !run_r)
         begin
            run_r <= 1'b1;
            cnt_r <= 4'h0;
         end
         else if (run_r)
         begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(2 * DLY))
            begin
               run_r <= 1'b0;
            end
         end
      end
   end
endmodule

/* File: verif/hirq_status_tb.sv */
// Self-checking bench for the host interrupt status flag logic.
// Assumes the design header for offsets; firmware strobes come from the partner model.
`timescale 1ns/1ps
`include "hirq_params.svh"
module hirq_status_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ret = 1'b0;
   logic fifo = 1'b0;
   logic resp = 1'b0;
   logic fatal = 1'b0;
   logic go = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [1:0] cause = 2'h0;
   logic [7:0] rdata;
   logic [7:0] v;
   logic init_done, upload_start, host_irq, async_mode, irq_cfg_valid;
   int err_total = 0;
   int comparisons = 0;

   always #2.5 clk = ~clk;

   hirq_status dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rst_cause(cause), .retained_cfg_async(ret), .fifo_not_empty(fifo),
      .resp_pending(resp), .fatal_err(fatal), .init_done(init_done),
      .upload_start(upload_start), .rdata(rdata), .host_irq(host_irq),
      .async_mode(async_mode), .irq_cfg_valid(irq_cfg_valid));

   hirq_fw_model #(.DLY(2)) fw (.clk(clk), .rst(rst), .go(go), .init_done(init_done),
      .upload_start(upload_start));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic do_reset(input logic [1:0] c, input logic r);
      @(posedge clk);
      cause <= c;
      ret <= r;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic wait_irq(input int n);
      int i;
      for (i = 0; i < n && host_irq !== 1'b1; i++)
         @(posedge clk);
      if (host_irq !== 1'b1)
      begin
         err_total++;
         $display("unexpected at %0t: interrupt never rose", $time);
         end_sim();
      end
   endtask

   task automatic pulse_fatal();
      @(posedge clk);
      fatal <= 1'b1;
      @(posedge clk);
      fatal <= 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset_vals();
      rd_reg(`HIRQ_OFS_STATUS, v);
      chk(v, 8'h80, "status after reset");
      @(posedge clk) #1 chk(rdata, 8'h00, "read data after slot");
      rd_reg(`HIRQ_OFS_MASK, v);
      chk(v, 8'h07, "mask reset");
      rd_reg(`HIRQ_OFS_LINKCFG, v);
      chk(v, 8'h00, "linkcfg reset");
      rd_reg(`HIRQ_OFS_IRQCFG, v);
      chk(v, 8'h00, "irqcfg reset");
      rd_reg(4'hF, v);
      chk(v, 8'h00, "unmapped read");
      wr_reg(`HIRQ_OFS_MASK, 8'h00);
      repeat (6) @(posedge clk);
      chk({7'h00, host_irq}, 8'h00, "irq before configuration");
      wr_reg(`HIRQ_OFS_MASK, 8'h07);
      $display("test reset values done");
   endtask

   task automatic t_boot();
      int i;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 20 && upload_start !== 1'b1; i++)
         @(posedge clk);
      if (upload_start !== 1'b1)
      begin
         err_total++;
         $display("unexpected at %0t: upload strobe never came", $time);
         end_sim();
      end
      repeat (3) @(posedge clk);
      rd_reg(`HIRQ_OFS_STATUS, v);
      chk(v, 8'h00, "reset flag after upload");
      rd_reg(`HIRQ_OFS_CTRL, v);
      chk(v, 8'h03, "init and upload flags");
      $display("test boot done");
   endtask

   task automatic t_flags();
      logic [2:0] tbl [4] = '{3'b001, 3'b010, 3'b111, 3'b100};
      logic [7:0] exp [4] = '{8'h20, 8'h40, 8'h40, 8'h00};
      int i;
      for (i = 0; i < 4; i++)
      begin
         wr_reg(`HIRQ_OFS_LINKCFG, {7'h00, tbl[i][2]});
         @(posedge clk);
         fifo <= tbl[i][1];
         resp <= tbl[i][0];
         repeat (3) @(posedge clk);
         chk({7'h00, async_mode}, {7'h00, tbl[i][2]}, "async mode");
         rd_reg(`HIRQ_OFS_STATUS, v);
         chk(v, exp[i], "status flags");
      end
      $display("test status flags done");
   endtask

   task automatic t_hold();
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(`HIRQ_OFS_LINKCFG, 8'h00);
      pulse_fatal();
      @(posedge clk);
      ce <= 1'b1;
      rd_reg(`HIRQ_OFS_LINKCFG, v);
      chk(v, 8'h01, "write while frozen");
      rd_reg(`HIRQ_OFS_CTRL, v);
      chk(v & 8'h04, 8'h00, "fatal while frozen");
      $display("test clock enable done");
   endtask

   task automatic t_fatal();
      wr_reg(`HIRQ_OFS_IRQCFG, 8'h01);
      wr_reg(`HIRQ_OFS_EVT, 8'h07);
      wr_reg(`HIRQ_OFS_MASK, 8'h05);
      @(posedge clk);
      chk({7'h00, irq_cfg_valid}, 8'h01, "irq config valid");
      pulse_fatal();
      wait_irq(8);
      rd_reg(`HIRQ_OFS_STATUS, v);
      chk(v, 8'h80, "fatal flag");
      rd_reg(`HIRQ_OFS_EVT, v);
      chk(v & 8'h02, 8'h02, "fatal event");
      wr_reg(`HIRQ_OFS_EVT, 8'h02);
      repeat (3) @(posedge clk);
      chk({7'h00, host_irq}, 8'h00, "irq after clear");
      wr_reg(`HIRQ_OFS_CTRL, 8'h04);
      rd_reg(`HIRQ_OFS_STATUS, v);
      chk(v, 8'h00, "fatal flag cleared");
      wr_reg(`HIRQ_OFS_MASK, 8'h07);
      pulse_fatal();
      repeat (4) @(posedge clk);
      chk({7'h00, host_irq}, 8'h00, "masked fatal");
      $display("test fatal done");
   endtask

   task automatic t_wdog();
      do_reset(2'h1, 1'b1);
      rd_reg(`HIRQ_OFS_STATUS, v);
      chk(v, 8'h80, "reset flag after watchdog reset");
      wr_reg(`HIRQ_OFS_MASK, 8'h00);
      wait_irq(8);
      chk({7'h00, host_irq}, 8'h01, "watchdog reset irq");
      do_reset(2'h2, 1'b1);
      wr_reg(`HIRQ_OFS_MASK, 8'h00);
      wait_irq(8);
      chk({7'h00, host_irq}, 8'h01, "fatal reset irq");
      do_reset(2'h1, 1'b0);
      wr_reg(`HIRQ_OFS_MASK, 8'h00);
      repeat (6) @(posedge clk);
      chk({7'h00, host_irq}, 8'h00, "watchdog reset without retained config");
      do_reset(2'h0, 1'b1);
      wr_reg(`HIRQ_OFS_MASK, 8'h00);
      repeat (6) @(posedge clk);
      chk({7'h00, host_irq}, 8'h00, "power-on reset irq");
      $display("test watchdog done");
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      do_reset(2'h0, 1'b0);
      t_reset_vals();
      t_boot();
      t_flags();
      t_hold();
      t_fatal();
      t_wdog();
      end_sim();
   end
endmodule
